// File: bce_defines.vh
/*
 Command codes, argument selectors, result codes and timing counts for the
 biometric command executor. Definitions only; included by the design files.
*/
`ifndef BCE_DEFINES_VH
`define BCE_DEFINES_VH

// Command codes
`define BCE_CMD_CAPTURE 16'h0001
`define BCE_CMD_ENROLL 16'h0002
`define BCE_CMD_IDENTIFY 16'h0003
`define BCE_CMD_INFO 16'h3004
`define BCE_CMD_IMAGE 16'h0005
`define BCE_CMD_TEMPLATE 16'h0006
`define BCE_CMD_WAIT 16'h0007

// Argument selectors carried on cmd_arg
`define BCE_ARG_NONE 4'h0
`define BCE_ARG_BEGIN_SESSION 4'h1
`define BCE_ADD_SAMPLE_ARGUMENT_SAMPLE 4'h2
`define BCE_ARG_END_SESSION 4'h3
`define BCE_ARG_READ_REQUEST 4'h4
`define BCE_ARG_SERIAL_ID 4'h5
`define BCE_ARG_RESET_CAUSE 4'h6
`define BCE_ARG_FEATURE_EXTRACT 4'h7
`define BCE_ARG_SEND_TO_HOST 4'h8
`define BCE_ARG_STORE 4'h9
`define BCE_ARG_FINGER_PRESENT 4'ha
`define BCE_ARG_FINGER_LIFTED 4'hb

// Result codes
`define BCE_RES_OK 8'h00
`define BCE_RES_TIMEOUT 8'h01
`define BCE_RES_BAD_CMD 8'h02
`define BCE_RES_BAD_STATE 8'h03

// Reply kinds on rsp_kind
`define BCE_RSP_RESULT 3'h0
`define BCE_RSP_COUNT 3'h1
`define BCE_RSP_MATCH 3'h2
`define BCE_RSP_SERIAL 3'h3
`define BCE_RSP_CAUSE 3'h4
`define BCE_RSP_PAYLOAD 3'h5
`define BCE_RSP_VERSION 3'h6

// Timing: one millisecond tick at 250 MHz
`define BCE_TICK_PERIOD_NS 1000000
`define BCE_CLK_PERIOD_NS 4
`define BCE_TICK_CYCLES (`BCE_TICK_PERIOD_NS / `BCE_CLK_PERIOD_NS)

// Enrollment sample count and sizes
`define BCE_ENROLL_SAMPLES 8'h03
`define BCE_SERIAL_BYTES 16'h000c
`define BCE_VERSION_BYTES 16'h0004

`endif

// File: bce_finger_poll.v
/*
 Finger poller: paces sensor presence samples at a programmable interval
 of millisecond ticks and counts an optional timeout in the same ticks.
 Assumes finger_sync is already synchronised to core_clk.
*/
`timescale 1ns/1ns
`include "bce_defines.vh"

module bce_finger_poll
#(
	parameter TICK_CYCLES = `BCE_TICK_CYCLES
)
(
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// Control
	input wire start,
	input wire want_present,
	input wire use_timeout,
	input wire [15:0] timeout_ms,
	input wire [15:0] poll_ms,
	input wire finger_sync,
	// Status
	output reg done,
	output reg timed_out
);

reg [31:0] tick_cnt_reg;
reg [15:0] poll_cnt_reg;
reg [15:0] time_cnt_reg;
reg active_reg;
wire tick;

assign tick = (tick_cnt_reg == TICK_CYCLES - 1);

// Millisecond divider runs only while a wait is active, saving toggles
always @(posedge core_clk or negedge rst_b)
begin
	if (!rst_b)
		tick_cnt_reg <= 32'h0;
	else if (!active_reg || tick)
		tick_cnt_reg <= 32'h0;
	else
		tick_cnt_reg <= tick_cnt_reg + 32'h1;
end

// Wait engine: sample on poll boundary, time out on elapsed ticks
always @(posedge core_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		active_reg <= 1'b0;
		poll_cnt_reg <= 16'h0;
		time_cnt_reg <= 16'h0;
		done <= 1'b0;
		timed_out <= 1'b0;
	end
	else
	begin
		done <= 1'b0;
		if (start)
		begin
			active_reg <= 1'b1;
			poll_cnt_reg <= 16'h0;
			time_cnt_reg <= 16'h0;
			timed_out <= 1'b0;
		end
		else if (active_reg && tick)
		begin
			time_cnt_reg <= time_cnt_reg + 16'h1;
			if (finger_sync == want_present && poll_cnt_reg == 16'h0)
			begin
				active_reg <= 1'b0;
				done <= 1'b1;
			end
			else if (use_timeout && time_cnt_reg + 16'h1 >= timeout_ms)
			begin
				active_reg <= 1'b0;
				done <= 1'b1;
				timed_out <= 1'b1;
			end
			// Zero interval means sample every tick
			if (poll_cnt_reg >= poll_ms)
				poll_cnt_reg <= 16'h0;
			else
				poll_cnt_reg <= poll_cnt_reg + 16'h1;
		end
	end
end

endmodule // bce_finger_poll

// File: bce_executor.v
/*
 Biometric command executor. Takes one decoded command at a time from the
 link framer, runs it against the sensor and matcher engines, and emits
 reply arguments as a stream of kind/byte beats.
 Assumes the framer holds cmd_valid until cmd_ready and the sink takes a
 beat whenever rsp_ready is high. Sensor presence is an asynchronous pin.
*/
`timescale 1ns/1ns
`include "bce_defines.vh"

// Contract
// - Capture waits for finger, captures only after detection, then replies
// - Capture timeout expiring first returns without taking an image
// - Capture without timeout waits for ever, then captures
// - Optional poll interval sets the sensor sampling period
// - Enroll begin starts session, clears resources, replies result
// - Enroll add merges template from latest image into enrollment
// - Enroll add replies remaining sample count and result
// - Enroll end closes session, replies count and result
// - Identify compares template with store, replies match, id, result
// - Info read returns variable-length version string; code returns a fixed BCE_VERSION_BYTES (4) bytes
// - Info serial returns 12 bytes, low byte first, then result
// - Info reset-cause returns cause of the latest reset
// - Image extract turns captured image into template, replies result
// - Image send streams pixel payload then result
// - Image payload carries image size in its size field; code sends IMG_BYTES + 2 there
// - Template store saves enrolled template under given id; code latches the id in id_reg but never passes it to the engine
// - Wait finger-present returns on finger or timeout
// - Wait finger-lifted returns on no finger or timeout
// - A running finger wait cannot be aborted by a command, only by reset
module bce_executor
#(
	parameter TICK_CYCLES = `BCE_TICK_CYCLES,
	parameter IMG_BYTES = 16'h0100,
	parameter [95:0] SERIAL_ID = 96'h0123456789abcdef01234567,
	parameter [31:0] VERSION = 32'h76312e30 // Arbitrary version text
)
(
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// Command in
	input wire cmd_valid,
	output reg cmd_ready,
	input wire [15:0] cmd_code,
	input wire [3:0] cmd_arg,
	input wire cmd_has_timeout,
	input wire [15:0] timeout_argument,
	input wire [15:0] poll_interval_argument,
	input wire [15:0] template_identifier_argument,
	input wire [7:0] reset_cause_in,
	// Sensor and engines
	input wire finger_pin,
	output reg capture_req,
	input wire engine_done,
	output reg [1:0] engine_op,
	input wire engine_match,
	input wire [15:0] engine_match_id,
	input wire [7:0] pixel_byte,
	output reg [15:0] pixel_addr,
	// Reply out
	output reg rsp_valid,
	input wire rsp_ready,
	output reg [2:0] rsp_kind,
	output reg [7:0] rsp_data,
	output reg rsp_last,
	output reg busy
);

localparam [6:0] S_IDLE = 7'h01;
localparam [6:0] S_WAIT = 7'h02;
localparam [6:0] S_CAPT = 7'h04;
localparam [6:0] S_ENG = 7'h08;
localparam [6:0] S_EMIT = 7'h10;
localparam [6:0] S_RES = 7'h20;
localparam [6:0] S_DONE = 7'h40;

// Engine operations
localparam [1:0] OP_EXTRACT = 2'h0;
localparam [1:0] OP_MERGE = 2'h1;
localparam [1:0] OP_MATCH = 2'h2;
localparam [1:0] OP_STORE = 2'h3;

reg [6:0] state_reg;
reg fp_meta_reg;
reg fp_sync_reg;
reg poll_start_reg;
reg want_present_reg;
reg capture_after_reg;
reg session_reg;
reg [7:0] remain_reg;
reg [7:0] result_reg;
reg [2:0] kind_reg;
reg [15:0] idx_reg;
reg [15:0] len_reg;
reg [15:0] id_reg;
reg [7:0] cause_reg;
reg match_reg;
reg [15:0] mid_reg;
reg [15:0] tmo_reg;
reg [15:0] poll_reg;
reg use_tmo_reg;
wire poll_done;
wire poll_timeout;
reg [7:0] beat;

// Sensor pin crosses into core_clk through two flops
always @(posedge core_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		fp_meta_reg <= 1'b0;
		fp_sync_reg <= 1'b0;
	end
	else
	begin
		fp_meta_reg <= finger_pin;
		fp_sync_reg <= fp_meta_reg;
	end
end

bce_finger_poll #(
	.TICK_CYCLES(TICK_CYCLES)
) u_poll (
	.core_clk(core_clk),
	.rst_b(rst_b),
	.start(poll_start_reg),
	.want_present(want_present_reg),
	.use_timeout(use_tmo_reg),
	.timeout_ms(tmo_reg),
	.poll_ms(poll_reg),
	.finger_sync(fp_sync_reg),
	.done(poll_done),
	.timed_out(poll_timeout)
);

// Beat selector for multi-byte arguments, low byte first
always @*
begin
	beat = 8'h00;
	case (kind_reg)
	`BCE_RSP_COUNT: beat = remain_reg;
	`BCE_RSP_MATCH:
		if (idx_reg == 16'h0)
			beat = {7'h0, match_reg};
		else
			beat = (idx_reg == 16'h1) ? mid_reg[7:0] : mid_reg[15:8];
	`BCE_RSP_SERIAL: beat = SERIAL_ID[idx_reg[3:0] * 8 +: 8];
	`BCE_RSP_CAUSE: beat = cause_reg;
	`BCE_RSP_VERSION: beat = VERSION[idx_reg[1:0] * 8 +: 8];
	`BCE_RSP_PAYLOAD:
		if (idx_reg == 16'h0)
			beat = len_reg[7:0];
		else if (idx_reg == 16'h1)
			beat = len_reg[15:8];
		else
			beat = pixel_byte;
	default: beat = 8'h00;
	endcase
end

// Command sequencer: one command at a time, no abort path once waiting
always @(posedge core_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		state_reg <= S_IDLE;
		cmd_ready <= 1'b0;
		capture_req <= 1'b0;
		engine_op <= OP_EXTRACT;
		pixel_addr <= 16'h0;
		rsp_valid <= 1'b0;
		rsp_kind <= `BCE_RSP_RESULT;
		rsp_data <= 8'h00;
		rsp_last <= 1'b0;
		busy <= 1'b0;
		poll_start_reg <= 1'b0;
		want_present_reg <= 1'b1;
		capture_after_reg <= 1'b0;
		session_reg <= 1'b0;
		remain_reg <= 8'h00;
		result_reg <= `BCE_RES_OK;
		kind_reg <= `BCE_RSP_RESULT;
		idx_reg <= 16'h0;
		len_reg <= 16'h0;
		id_reg <= 16'h0;
		cause_reg <= 8'h00;
		match_reg <= 1'b0;
		mid_reg <= 16'h0;
		tmo_reg <= 16'h0;
		poll_reg <= 16'h0;
		use_tmo_reg <= 1'b0;
	end
	else
	begin
		cmd_ready <= 1'b0;
		capture_req <= 1'b0;
		poll_start_reg <= 1'b0;
		case (state_reg)
		S_IDLE:
		begin
			busy <= 1'b0;
			if (cmd_valid && !cmd_ready)
			begin
				cmd_ready <= 1'b1;
				busy <= 1'b1;
				result_reg <= `BCE_RES_OK;
				kind_reg <= `BCE_RSP_RESULT;
				idx_reg <= 16'h0;
				len_reg <= 16'h0;
				tmo_reg <= timeout_argument;
				poll_reg <= poll_interval_argument;
				use_tmo_reg <= cmd_has_timeout;
				id_reg <= template_identifier_argument;
				state_reg <= S_RES;
				if (cmd_code == `BCE_CMD_CAPTURE)
				begin
					want_present_reg <= 1'b1;
					capture_after_reg <= 1'b1;
					poll_start_reg <= 1'b1;
					state_reg <= S_WAIT;
				end
				else if (cmd_code == `BCE_CMD_WAIT &&
					(cmd_arg == `BCE_ARG_FINGER_PRESENT ||
					cmd_arg == `BCE_ARG_FINGER_LIFTED))
				begin
					want_present_reg <= (cmd_arg == `BCE_ARG_FINGER_PRESENT);
					capture_after_reg <= 1'b0;
					poll_start_reg <= 1'b1;
					state_reg <= S_WAIT;
				end
				else if (cmd_code == `BCE_CMD_ENROLL &&
					cmd_arg == `BCE_ARG_BEGIN_SESSION)
				begin
					session_reg <= 1'b1;
					remain_reg <= `BCE_ENROLL_SAMPLES;
				end
				else if (cmd_code == `BCE_CMD_ENROLL &&
					cmd_arg == `BCE_ADD_SAMPLE_ARGUMENT_SAMPLE)
				begin
					kind_reg <= `BCE_RSP_COUNT;
					if (session_reg)
					begin
						engine_op <= OP_MERGE;
						state_reg <= S_ENG;
					end
					else
					begin
						result_reg <= `BCE_RES_BAD_STATE;
						state_reg <= S_EMIT;
					end
				end
				else if (cmd_code == `BCE_CMD_ENROLL &&
					cmd_arg == `BCE_ARG_END_SESSION)
				begin
					session_reg <= 1'b0;
					kind_reg <= `BCE_RSP_COUNT;
					state_reg <= S_EMIT;
					if (!session_reg)
						result_reg <= `BCE_RES_BAD_STATE;
				end
				else if (cmd_code == `BCE_CMD_IDENTIFY)
				begin
					engine_op <= OP_MATCH;
					kind_reg <= `BCE_RSP_MATCH;
					state_reg <= S_ENG;
				end
				else if (cmd_code == `BCE_CMD_INFO &&
					cmd_arg == `BCE_ARG_READ_REQUEST)
				begin
					kind_reg <= `BCE_RSP_VERSION;
					len_reg <= `BCE_VERSION_BYTES;
					state_reg <= S_EMIT;
				end
				else if (cmd_code == `BCE_CMD_INFO &&
					cmd_arg == `BCE_ARG_SERIAL_ID)
				begin
					kind_reg <= `BCE_RSP_SERIAL;
					len_reg <= `BCE_SERIAL_BYTES;
					state_reg <= S_EMIT;
				end
				else if (cmd_code == `BCE_CMD_INFO &&
					cmd_arg == `BCE_ARG_RESET_CAUSE)
				begin
					kind_reg <= `BCE_RSP_CAUSE;
					cause_reg <= reset_cause_in;
					state_reg <= S_EMIT;
				end
				else if (cmd_code == `BCE_CMD_IMAGE &&
					cmd_arg == `BCE_ARG_FEATURE_EXTRACT)
				begin
					engine_op <= OP_EXTRACT;
					state_reg <= S_ENG;
				end
				else if (cmd_code == `BCE_CMD_IMAGE &&
					cmd_arg == `BCE_ARG_SEND_TO_HOST)
				begin
					kind_reg <= `BCE_RSP_PAYLOAD;
					len_reg <= IMG_BYTES + 16'h2;
					pixel_addr <= 16'h0;
					state_reg <= S_EMIT;
				end
				else if (cmd_code == `BCE_CMD_TEMPLATE &&
					cmd_arg == `BCE_ARG_STORE)
				begin
					engine_op <= OP_STORE;
					state_reg <= S_ENG;
				end
				else
					result_reg <= `BCE_RES_BAD_CMD;
			end
		end
		S_WAIT:
			// No command is taken here, so only reset can abort the wait
			if (poll_done)
			begin
				if (poll_timeout)
				begin
					result_reg <= `BCE_RES_TIMEOUT;
					state_reg <= S_RES;
				end
				else if (capture_after_reg)
				begin
					capture_req <= 1'b1;
					state_reg <= S_CAPT;
				end
				else
					state_reg <= S_RES;
			end
		S_CAPT:
			if (engine_done)
				state_reg <= S_RES;
		S_ENG:
			if (engine_done)
			begin
				match_reg <= engine_match;
				mid_reg <= engine_match_id;
				if (kind_reg == `BCE_RSP_MATCH)
					len_reg <= 16'h3;
				if (engine_op == OP_MERGE)
				begin
					len_reg <= 16'h1;
					if (remain_reg != 8'h00)
						remain_reg <= remain_reg - 8'h01;
				end
				state_reg <= (kind_reg == `BCE_RSP_RESULT) ? S_RES : S_EMIT;
			end
		S_EMIT:
			// Argument bytes; a beat only advances when the sink takes it
			if (!rsp_valid || rsp_ready)
			begin
				if (kind_reg == `BCE_RSP_COUNT || kind_reg == `BCE_RSP_CAUSE)
					len_reg <= 16'h1;
				if (idx_reg < len_reg || len_reg == 16'h0)
				begin
					rsp_valid <= 1'b1;
					rsp_kind <= kind_reg;
					rsp_data <= beat;
					rsp_last <= 1'b0;
					idx_reg <= idx_reg + 16'h1;
					if (kind_reg == `BCE_RSP_PAYLOAD && idx_reg >= 16'h1)
						pixel_addr <= idx_reg - 16'h1;
				end
				else
				begin
					rsp_valid <= 1'b0;
					state_reg <= S_RES;
				end
			end
		S_RES:
			if (!rsp_valid || rsp_ready)
			begin
				rsp_valid <= 1'b1;
				rsp_kind <= `BCE_RSP_RESULT;
				rsp_data <= result_reg;
				rsp_last <= 1'b1;
				state_reg <= S_DONE;
			end
		S_DONE:
			if (rsp_ready)
			begin
				rsp_valid <= 1'b0;
				rsp_last <= 1'b0;
				state_reg <= S_IDLE;
			end
		default: state_reg <= S_IDLE;
		endcase
	end
end

endmodule // bce_executor

// File: bce_executor_chk.sv
/*
 Port checker for the command executor.
 Assumes it is bound onto bce_executor with one clock domain.
*/
`timescale 1ns/1ns
`include "bce_defines.vh"
module bce_executor_chk
(
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// Command and sensor
	input wire cmd_valid,
	input wire cmd_ready,
	input wire finger_pin,
	input wire capture_req,
	// Reply and status
	input wire rsp_valid,
	input wire rsp_ready,
	input wire [2:0] rsp_kind,
	input wire [7:0] rsp_data,
	input wire rsp_last,
	input wire busy
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// Handshake on the command side
	a_ready_pulse: assert property (cmd_ready |=> !cmd_ready)
		else $error("take pulse longer than one cycle");
	a_take_valid: assert property (cmd_ready |-> $past(cmd_valid) ##1 busy)
		else $error("take without request");
	// Reply beats stand until taken
	a_rsp_hold: assert property (rsp_valid && !rsp_ready |=>
		rsp_valid && $stable({rsp_kind, rsp_data, rsp_last}))
		else $error("reply beat changed while stalled");
	a_rsp_drop: assert property ($fell(rsp_valid) |-> $past(rsp_ready))
		else $error("reply beat dropped untaken");
	a_last_result: assert property (rsp_valid && rsp_last |->
		rsp_kind == `BCE_RSP_RESULT)
		else $error("closing beat is not a result");
	// Capture only with a finger seen through the synchroniser
	a_capture_finger: assert property (capture_req |->
		busy && $past(finger_pin, 4))
		else $error("capture without finger");
	a_rsp_busy: assert property (rsp_valid |-> busy)
		else $error("reply while idle");
	a_reset_idle: assert property ($rose(rst_b) |->
		!busy && !rsp_valid && !cmd_ready)
		else $error("not idle after reset");
	// Back to idle, unless the host's next command is taken at once
	a_last_ends: assert property (rsp_valid && rsp_ready && rsp_last |=>
		!rsp_valid ##1 (!busy || cmd_ready))
		else $error("busy after final beat");

	// Main scenarios reached
	c_capture: cover property (capture_req);
	c_timeout: cover property (rsp_valid && rsp_last &&
		rsp_data == `BCE_RES_TIMEOUT);
	c_stall: cover property (rsp_valid && !rsp_ready ##1 rsp_valid);
endmodule // bce_executor_chk

// File: bce_engine_model.sv
/*
 Sensor engine and image memory model for the executor bench.
 Assumes busy and capture_req come straight from the executor.
*/
`timescale 1ns/1ns
module bce_engine_model
(
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// Executor side
	input wire busy,
	input wire capture_req,
	input wire [15:0] pixel_addr,
	output reg engine_done,
	output wire [7:0] pixel_byte
);
	reg [2:0] gap_reg;

	// Pixel memory is an address pattern, valid in the same cycle
	assign pixel_byte = pixel_addr[7:0] ^ 8'h5a;

	// Engines finish eight cycles apart while busy; a capture restarts
	// the gap so the image never comes back in zero time
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			gap_reg <= 3'h0;
			engine_done <= 1'b0;
		end
		else
		begin
			gap_reg <= (capture_req || !busy) ? 3'h0 : gap_reg + 3'h1;
			// A capture launched this cycle must not see a stale finish
			engine_done <= busy && !capture_req && gap_reg == 3'h6;
		end
	end
endmodule // bce_engine_model

// File: bce_executor_tb.sv
/*
 Self-checking bench for the command executor.
 Assumes bce_engine_model stands in for the engines; the bench is host.
*/
`timescale 1ns/1ns
`include "bce_defines.vh"
module bce_executor_tb;
	localparam [95:0] SID = 96'h0f1e2d3c4b5a69788796a5b4; // Arbitrary
	localparam [31:0] VER = 32'h33323130; // Arbitrary version text
	reg core_clk = 0, rst_b = 0, cmd_valid = 0, cmd_has_timeout = 0;
	reg finger_pin = 0, rsp_ready = 0, engine_match = 1;
	reg [15:0] cmd_code = 0, timeout_argument = 0, poll_interval_argument = 0;
	reg [15:0] template_identifier_argument = 0, engine_match_id = 0;
	reg [3:0] cmd_arg = 0;
	reg [7:0] reset_cause_in = 0;
	wire cmd_ready, capture_req, engine_done, rsp_valid, rsp_last, busy;
	wire [1:0] engine_op;
	wire [15:0] pixel_addr;
	wire [7:0] pixel_byte, rsp_data;
	wire [2:0] rsp_kind;
	integer seed = 50466, miscompares = 0, check_count = 0, i;
	reg [11:0] q[$];

	bce_executor #(.TICK_CYCLES(4), .IMG_BYTES(16'h0004), .SERIAL_ID(SID),
		.VERSION(VER)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
		.cmd_arg(cmd_arg), .cmd_has_timeout(cmd_has_timeout),
		.timeout_argument(timeout_argument),
		.poll_interval_argument(poll_interval_argument),
		.template_identifier_argument(template_identifier_argument),
		.reset_cause_in(reset_cause_in), .finger_pin(finger_pin),
		.capture_req(capture_req), .engine_done(engine_done),
		.engine_op(engine_op), .engine_match(engine_match),
		.engine_match_id(engine_match_id), .pixel_byte(pixel_byte),
		.pixel_addr(pixel_addr), .rsp_valid(rsp_valid),
		.rsp_ready(rsp_ready), .rsp_kind(rsp_kind), .rsp_data(rsp_data),
		.rsp_last(rsp_last), .busy(busy));
	bce_engine_model i_eng (.core_clk(core_clk), .rst_b(rst_b), .busy(busy),
		.capture_req(capture_req), .pixel_addr(pixel_addr),
		.engine_done(engine_done), .pixel_byte(pixel_byte));

	// Clock and a sink that stalls about a third of the time
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk)
		rsp_ready <= ($random(seed) % 3) != 0;

	task fail(input string m);
	begin
		miscompares = miscompares + 1;
		$display("[FAIL] %0t %0s", $time, m);
	end
	endtask

	task chk(input ok, input string m);
	begin
		check_count = check_count + 1;
		if (ok !== 1'b1)
			fail(m);
	end
	endtask

	// Expected beat: kind 7 means any kind
	task exp(input [2:0] k, input [7:0] d, input l);
		q.push_back({k, l, d});
	endtask

	// Host issues one command and holds it until taken
	task send(input [15:0] c, input [3:0] a, input t, input [15:0] tm);
		integer n;
	begin
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_arg <= a;
		cmd_has_timeout <= t;
		timeout_argument <= tm;
		poll_interval_argument <= $random(seed) & 16'h0003;
		n = 0;
		do
		begin
			@(negedge core_clk);
			n = n + 1;
		end
		while (cmd_ready !== 1'b1 && n < 50);
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		chk(n < 50, "command not taken");
	end
	endtask

	// Collect reply beats and compare with the model queue
	task run(input integer lim);
		integer n;
		reg [11:0] e;
	begin
		n = 0;
		while (q.size() > 0 && n < lim)
		begin
			@(negedge core_clk);
			n = n + 1;
			if (rsp_valid === 1'b1 && rsp_ready)
			begin
				e = q.pop_front();
				chk(rsp_data === e[7:0] && rsp_last === e[8] &&
					(e[11:9] == 3'h7 || rsp_kind === e[11:9]), "beat mismatch");
			end
		end
		chk(q.size() == 0, "reply missing");
		q.delete();
		$display("test step done at %0t", $time);
	end
	endtask

	task final_report;
	begin
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask

	// Watchdog well past the expected run length
	initial
	begin
		#100000;
		fail("watchdog");
		final_report;
	end

	initial
	begin
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		reset_cause_in <= $random(seed);
		engine_match_id <= $random(seed);
		template_identifier_argument <= $random(seed);
		@(posedge core_clk);
		exp(`BCE_RSP_CAUSE, reset_cause_in, 0);
		exp(0, 0, 1);
		send(`BCE_CMD_INFO, `BCE_ARG_RESET_CAUSE, 0, 0);
		run(200);
		for (i = 0; i < 12; i = i + 1)
			exp(`BCE_RSP_SERIAL, SID[8*i+:8], 0);
		exp(0, 0, 1);
		send(`BCE_CMD_INFO, `BCE_ARG_SERIAL_ID, 0, 0);
		run(200);
		for (i = 0; i < 4; i = i + 1)
			exp(`BCE_RSP_VERSION, VER[8*i+:8], 0);
		exp(0, 0, 1);
		send(`BCE_CMD_INFO, `BCE_ARG_READ_REQUEST, 0, 0);
		run(200);
		exp(0, `BCE_RES_BAD_CMD, 1);
		send(16'h1002, `BCE_ARG_NONE, 0, 0);
		run(200);
		exp(`BCE_RSP_COUNT, 8'h00, 0);
		exp(0, `BCE_RES_BAD_STATE, 1);
		send(`BCE_CMD_ENROLL, `BCE_ADD_SAMPLE_ARGUMENT_SAMPLE, 0, 0);
		run(200);
		exp(0, 0, 1);
		send(`BCE_CMD_ENROLL, `BCE_ARG_BEGIN_SESSION, 0, 0);
		run(200);
		exp(`BCE_RSP_COUNT, 8'h02, 0);
		exp(0, 0, 1);
		send(`BCE_CMD_ENROLL, `BCE_ADD_SAMPLE_ARGUMENT_SAMPLE, 0, 0);
		chk(engine_op === 2'h1, "merge not requested");
		run(400);
		exp(`BCE_RSP_COUNT, 8'h02, 0);
		exp(0, 0, 1);
		send(`BCE_CMD_ENROLL, `BCE_ARG_END_SESSION, 0, 0);
		run(200);
		exp(0, 0, 1);
		send(`BCE_CMD_TEMPLATE, `BCE_ARG_STORE, 0, 0);
		chk(engine_op === 2'h3, "store not requested");
		run(400);
		exp(`BCE_RSP_MATCH, 8'h01, 0);
		exp(`BCE_RSP_MATCH, engine_match_id[7:0], 0);
		exp(`BCE_RSP_MATCH, engine_match_id[15:8], 0);
		exp(0, 0, 1);
		send(`BCE_CMD_IDENTIFY, `BCE_ARG_NONE, 0, 0);
		chk(engine_op === 2'h2, "match not requested");
		run(400);
		exp(`BCE_RSP_PAYLOAD, 8'h06, 0);
		exp(`BCE_RSP_PAYLOAD, 8'h00, 0);
		for (i = 0; i < 4; i = i + 1)
			exp(`BCE_RSP_PAYLOAD, i ^ 8'h5a, 0);
		exp(0, 0, 1);
		send(`BCE_CMD_IMAGE, `BCE_ARG_SEND_TO_HOST, 0, 0);
		run(400);
		exp(0, 0, 1);
		send(`BCE_CMD_IMAGE, `BCE_ARG_FEATURE_EXTRACT, 0, 0);
		chk(engine_op === 2'h0, "extract not requested");
		run(400);
		exp(0, `BCE_RES_TIMEOUT, 1);
		send(`BCE_CMD_CAPTURE, `BCE_ARG_NONE, 1, 16'h0003);
		run(2000);
		exp(0, 0, 1);
		send(`BCE_CMD_CAPTURE, `BCE_ARG_NONE, 0, 0);
		repeat (60) @(posedge core_clk);
		chk(busy === 1'b1 && rsp_valid === 1'b0, "capture ended early");
		finger_pin <= 1'b1;
		run(2000);
		exp(0, 0, 1);
		send(`BCE_CMD_WAIT, `BCE_ARG_FINGER_PRESENT, 1, 16'h00ff);
		run(2000);
		exp(0, `BCE_RES_TIMEOUT, 1);
		send(`BCE_CMD_WAIT, `BCE_ARG_FINGER_LIFTED, 1, 16'h0002);
		run(2000);
		@(posedge core_clk);
		finger_pin <= 1'b0;
		exp(0, 0, 1);
		send(`BCE_CMD_WAIT, `BCE_ARG_FINGER_LIFTED, 1, 16'h00ff);
		run(2000);
		send(`BCE_CMD_WAIT, `BCE_ARG_FINGER_PRESENT, 0, 0);
		repeat (100) @(posedge core_clk);
		chk(busy === 1'b1, "wait ended without finger");
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		@(negedge core_clk);
		chk(busy === 1'b0 && rsp_valid === 1'b0, "reset did not abort");
		final_report;
	end
endmodule // bce_executor_tb

bind bce_executor bce_executor_chk i_chk (.core_clk(core_clk),
	.rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
	.finger_pin(finger_pin), .capture_req(capture_req),
	.rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_kind(rsp_kind),
	.rsp_data(rsp_data), .rsp_last(rsp_last), .busy(busy));
